// >>> shared/flash_seq_cfg.svh
// constants of the flash system-call sequencer
//----------------------------------------------------------------------
// Contract
// - one protection bit per row, per macro
// - chip protection byte in last byte
// - supervisory row as long as user row
// - protection call copies latch to supervisory
// - protection keys B6 E0, opcode 000D
// - chip level 01 open 02 prot 04 kill
// - bits 31..24 select macro zero or one
// - completion overwrites argument with status word
// - write row: preprogram, erase, program
// - interrupt at end of every phase
// - only resume accepted while operation pending
// - write row keys B6 DA, opcode 0007
// - program row has single phase
// - program row keys B6 DB, opcode 0008
//----------------------------------------------------------------------
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH

`define ADDR_ARG        12'h000
`define ADDR_REQ        12'h004
`define ADDR_STAT       12'h008
`define ADDR_CHIPPROT   12'h00C
`define KEY1            8'hB6
`define KEY2_PROT       8'hE0
`define KEY2_WRITE      8'hDA
`define KEY2_PROG       8'hDB
`define KEY2_RESUME     8'hDC
`define OP_PROT         16'h000D
`define OP_WRITE        16'h0007
`define OP_PROG         16'h0008
`define OP_RESUME       16'h0009
`define REQ_FLAG        16'h8000
`define LVL_OPEN        8'h01
`define LVL_PROT        8'h02
`define LVL_KILL        8'h04
`define ST_OK           32'hA0000000
`define ST_BADKEY       32'hF0000002
`define ST_BADADDR      32'hF0000004
`define ST_RESUME_DONE  32'hF0000007
`define ST_PENDING      32'hF0000008
`define ST_BUSY         32'hF0000009
`define PHASE_TIME_NS   1000
`define CLK_PERIOD_NS   5
`define PHASE_CYCLES    (`PHASE_TIME_NS / `CLK_PERIOD_NS)
`define CHIPPROT_RST    8'h01

`endif

// >>> shared/flash_seq_pkg.sv
// types of the flash system-call sequencer
package flash_seq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RUN     = 3'b001,
        ST_WAIT    = 3'b010
    } seq_state_t;

    typedef enum logic [1:0] {
        PH_PREPROG = 2'b00,
        PH_ERASE   = 2'b01,
        PH_PROGRAM = 2'b10,
        PH_PROTECT = 2'b11
    } phase_t;
endpackage

// >>> logic/phase_timer.sv
// phase duration counter for one flash operation phase
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module phase_timer #(
    parameter int CYCLES = `PHASE_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ce,
    input  wire logic start,
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);
    // refused at elaboration: a zero-length phase has no end pulse
    if (CYCLES < 1) begin : g_cycles_check
        $error("phase_timer: CYCLES must be at least 1");
    end

    logic [W-1:0] cnt_ff;
    logic         run_ff;
    wire          last = run_ff && (cnt_ff == W'(CYCLES - 1));

    // count from start until the phase length has elapsed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else if (ce) begin
            if (start) begin
                cnt_ff <= '0;
                run_ff <= 1'b1;
            end else if (last) begin
                run_ff <= 1'b0;
            end else if (run_ff) begin
                cnt_ff <= cnt_ff + W'(1);
            end
        end
    end

    assign done = ce && last;
endmodule

// >>> logic/flash_seq.sv
// flash system-call sequencer: protection, write row, program row
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module flash_seq
    import flash_seq_pkg::*;
#(
    parameter int ROWS        = 256,
    parameter int ROW_BYTES   = 64,
    parameter int MACROS      = 2,
    parameter int PHASE_CYC   = `PHASE_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] sram_param,
    output logic      [31:0] sram_addr,
    output logic             spc_irq,
    output logic             flash_op_valid,
    output logic      [1:0]  flash_op,
    output logic      [7:0]  flash_macro,
    output logic      [15:0] flash_row,
    output logic      [7:0]  chip_prot
);
    //------------------------------------------------------------------
    // elaboration checks and geometry
    //------------------------------------------------------------------
    localparam int PROT_BYTES = ROWS / 8;
    if (ROWS % 8 != 0) begin : g_rows_check
        $error("flash_seq: ROWS must divide by 8");
    end
    // protection bytes must fit one supervisory row
    if (PROT_BYTES > ROW_BYTES) begin : g_latch_check
        $error("flash_seq: latch too small");
    end
    if (MACROS < 1 || MACROS > 2) begin : g_macro_check
        $error("flash_seq: MACROS 1..2");
    end

    //------------------------------------------------------------------
    // state
    //------------------------------------------------------------------
    seq_state_t  state_ff, nxt_state;
    phase_t      phase_ff, nxt_phase;
    logic [31:0] arg_ff, nxt_arg;
    logic [31:0] req_ff, nxt_req;
    logic [7:0]  chip_prot_ff, nxt_chip_prot;
    logic [7:0]  macro_ff, nxt_macro;
    logic [15:0] row_ff, nxt_row;
    logic        irq_ff, nxt_irq;
    logic        is_write_ff, nxt_is_write;
    logic        fetch_ff, nxt_fetch;
    logic        start_ff, nxt_start;
    logic        phase_done;

    //------------------------------------------------------------------
    // apb decode; zero wait states, unmapped reads zero with error
    //------------------------------------------------------------------
    wire acc      = psel && penable;
    wire hit_arg  = (paddr == `ADDR_ARG);
    wire hit_req  = (paddr == `ADDR_REQ);
    wire hit_stat = (paddr == `ADDR_STAT);
    wire hit_chp  = (paddr == `ADDR_CHIPPROT);
    wire mapped   = hit_arg || hit_req || hit_stat || hit_chp;
    wire wr_arg   = ce && acc && pwrite && hit_arg;
    wire wr_req   = ce && acc && pwrite && hit_req;
    wire busy     = (state_ff != ST_IDLE);
    wire [31:0] stat_word = {26'h0, phase_ff, is_write_ff,
                             state_ff == ST_WAIT, state_ff == ST_RUN,
                             busy};
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = !acc      ? 32'h0000_0000 :
                     hit_arg   ? arg_ff :
                     hit_req   ? req_ff :
                     hit_stat  ? stat_word :
                     hit_chp   ? {24'h0, chip_prot_ff} : 32'h0000_0000;

    //------------------------------------------------------------------
    // request decode
    //------------------------------------------------------------------
    wire        call    = wr_req && (pwdata[31:16] == `REQ_FLAG);
    wire [15:0] op      = pwdata[15:0];
    // key check on the argument register for protection calls
    wire key_prot = (arg_ff[7:0] == `KEY1)
                 && (arg_ff[15:8] == `KEY2_PROT);
    wire [7:0] lvl   = arg_ff[23:16];
    wire [7:0] msel  = arg_ff[31:24];
    wire lvl_ok = (lvl == `LVL_OPEN) || (lvl == `LVL_PROT)
               || (lvl == `LVL_KILL);
    wire msel_ok = (msel < 8'(MACROS));
    // parameter word fetched from SRAM for the other calls
    wire key_ok_sram = (sram_param[7:0] == `KEY1);
    wire [7:0] key2  = sram_param[15:8];
    wire [15:0] prow = sram_param[31:16];
    wire row_ok = (prow < 16'(ROWS));

    //------------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------------
    always_comb begin
        nxt_state     = state_ff;
        nxt_phase     = phase_ff;
        nxt_arg       = wr_arg ? pwdata : arg_ff;
        nxt_req       = wr_req ? pwdata : req_ff;
        nxt_chip_prot = chip_prot_ff;
        nxt_macro     = macro_ff;
        nxt_row       = row_ff;
        nxt_irq       = 1'b0;
        nxt_is_write  = is_write_ff;
        nxt_fetch     = 1'b0;
        nxt_start     = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (fetch_ff) begin
                    // second cycle of a call: sram word now valid
                    if (!key_ok_sram) begin
                        nxt_arg = `ST_BADKEY;
                    end else if (req_ff[15:0] == `OP_RESUME) begin
                        nxt_arg = (key2 == `KEY2_RESUME)
                                ? `ST_RESUME_DONE : `ST_BADKEY;
                    end else if (req_ff[15:0] == `OP_WRITE
                                 && key2 == `KEY2_WRITE) begin
                        if (!row_ok) begin
                            nxt_arg = `ST_BADADDR;
                        end else begin
                            nxt_row      = prow;
                            nxt_is_write = 1'b1;
                            nxt_phase    = PH_PREPROG;
                            nxt_state    = ST_RUN;
                            nxt_start    = 1'b1;
                        end
                    end else if (req_ff[15:0] == `OP_PROG
                                 && key2 == `KEY2_PROG) begin
                        if (!row_ok) begin
                            nxt_arg = `ST_BADADDR;
                        end else begin
                            nxt_row      = prow;
                            nxt_is_write = 1'b0;
                            nxt_phase    = PH_PROGRAM;
                            nxt_state    = ST_RUN;
                            nxt_start    = 1'b1;
                        end
                    end else begin
                        nxt_arg = `ST_BADKEY;
                    end
                end else if (call && op == `OP_PROT) begin
                    if (!key_prot) begin
                        nxt_arg = `ST_BADKEY;
                    end else if (!msel_ok
                                 || (msel == 8'h00 && !lvl_ok)) begin
                        nxt_arg = `ST_BADADDR;
                    end else begin
                        nxt_macro    = msel;
                        nxt_is_write = 1'b0;
                        nxt_phase    = PH_PROTECT;
                        nxt_state    = ST_RUN;
                        nxt_start    = 1'b1;
                    end
                end else if (call) begin
                    nxt_fetch = 1'b1;    // read the sram parameter word
                end
            end
            ST_RUN: begin
                if (call) begin
                    nxt_arg = `ST_BUSY;
                end
                if (phase_done) begin
                    nxt_irq = 1'b1;
                    if (phase_ff == PH_PROTECT) begin
                        // chip level only lands with macro zero
                        if (macro_ff == 8'h00) begin
                            nxt_chip_prot = arg_ff[23:16];
                        end
                        nxt_arg   = `ST_OK;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_state = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (fetch_ff) begin
                    // resume keys come from the fetched sram word, so a
                    // stray pointer cannot start the next phase
                    if (!key_ok_sram || key2 != `KEY2_RESUME) begin
                        nxt_arg = `ST_BADKEY;
                    end else if (phase_ff == PH_PROGRAM) begin
                        nxt_arg   = `ST_OK;
                        nxt_state = ST_IDLE;
                    end else begin
                        // advance preprogram -> erase -> program
                        nxt_phase = (phase_ff == PH_PREPROG)
                                  ? PH_ERASE : PH_PROGRAM;
                        nxt_arg   = `ST_OK;
                        nxt_state = ST_RUN;
                        nxt_start = 1'b1;
                    end
                end else if (call && op == `OP_RESUME) begin
                    nxt_fetch = 1'b1;    // read the resume key word
                end else if (call) begin
                    nxt_arg = `ST_PENDING;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    //------------------------------------------------------------------
    // registers; everything frozen while ce is low
    //------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff     <= ST_IDLE;
            phase_ff     <= PH_PREPROG;
            arg_ff       <= 32'h0000_0000;
            req_ff       <= 32'h0000_0000;
            chip_prot_ff <= `CHIPPROT_RST;
            macro_ff     <= 8'h00;
            row_ff       <= 16'h0000;
            irq_ff       <= 1'b0;
            is_write_ff  <= 1'b0;
            fetch_ff     <= 1'b0;
            start_ff     <= 1'b0;
        end else if (ce) begin
            state_ff     <= nxt_state;
            phase_ff     <= nxt_phase;
            arg_ff       <= nxt_arg;
            req_ff       <= nxt_req;
            chip_prot_ff <= nxt_chip_prot;
            macro_ff     <= nxt_macro;
            row_ff       <= nxt_row;
            irq_ff       <= nxt_irq;
            is_write_ff  <= nxt_is_write;
            fetch_ff     <= nxt_fetch;
            start_ff     <= nxt_start;
        end
    end

    //------------------------------------------------------------------
    // phase timing
    //------------------------------------------------------------------
    phase_timer #(
        .CYCLES (PHASE_CYC)
    ) u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .start   (start_ff),
        .done    (phase_done)
    );

    //------------------------------------------------------------------
    // flash macro command outputs
    //------------------------------------------------------------------
    // the protection phase writes PROT_BYTES latch bytes into the
    // supervisory row, which has the user row length
    assign sram_addr      = arg_ff;           // parameter word pointer
    assign spc_irq        = irq_ff;
    assign flash_op_valid = (state_ff == ST_RUN);
    assign flash_op       = phase_ff;
    assign flash_macro    = macro_ff;
    assign flash_row      = row_ff;
    assign chip_prot      = chip_prot_ff;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    sequence s_phase_end;
        state_ff == ST_RUN && phase_done;
    endsequence

    // a resume whose fetched word carries the right keys
    sequence s_resume_ok;
        state_ff == ST_WAIT && fetch_ff && key_ok_sram
        && key2 == `KEY2_RESUME;
    endsequence

    a_irq_phase_end: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce and s_phase_end) |=> irq_ff)
        else $error("no interrupt at phase end");

    a_erase_after_pre: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_resume_ok and (ce && phase_ff == PH_PREPROG))
        |=> phase_ff == PH_ERASE)
        else $error("erase did not follow preprogram");

    a_prog_single: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_resume_ok and (ce && phase_ff == PH_PROGRAM))
        |=> state_ff == ST_IDLE)
        else $error("program row needed more than one resume");

    a_busy_refuse: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && state_ff == ST_WAIT && !fetch_ff && call
         && op != `OP_RESUME)
        |=> arg_ff == `ST_PENDING && state_ff == ST_WAIT)
        else $error("call accepted while pending");

    a_prot_status: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_phase_end and (ce && phase_ff == PH_PROTECT))
        |=> arg_ff == `ST_OK)
        else $error("protection status missing");

    a_bad_key: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && state_ff == ST_IDLE && !fetch_ff && call
         && op == `OP_PROT && !key_prot)
        |=> state_ff == ST_IDLE && arg_ff == `ST_BADKEY)
        else $error("bad key not refused");

    a_chip_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_phase_end and (ce && phase_ff == PH_PROTECT
         && macro_ff != 8'h00)) |=> $stable(chip_prot_ff))
        else $error("chip level changed from other macro");

    a_macro_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && state_ff == ST_IDLE && !fetch_ff && call
         && op == `OP_PROT && key_prot && msel_ok && lvl_ok)
        |=> flash_macro == $past(msel) ##1 flash_op_valid)
        else $error("macro select not applied");

    a_resume_key: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ce && state_ff == ST_WAIT && fetch_ff
         && !(key_ok_sram && key2 == `KEY2_RESUME))
        |=> state_ff == ST_WAIT && arg_ff == `ST_BADKEY)
        else $error("resume with bad key advanced the phase");
endmodule

// >>> tb/sram_param_model.sv
// sram model that answers the sequencer's parameter fetches
`timescale 1ns/1ps
module sram_param_model (
    input  wire logic        pclk,
    input  wire logic        ld,
    input  wire logic [3:0]  ld_idx,
    input  wire logic [31:0] ld_data,
    input  wire logic [31:0] sram_addr,
    output logic      [31:0] sram_param
);
    logic [31:0] mem [16];
    logic        hit;

    //------------------------------------------------------------
    // storage loaded by firmware once, before the first call
    //------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (ld) begin
            mem[ld_idx] <= ld_data;
        end
    end

    // words outside the model read back inverted, never a stale match
    assign hit        = (sram_addr[31:6] == 26'h0);
    assign sram_param = hit ? mem[sram_addr[5:2]] : ~mem[sram_addr[5:2]];
endmodule

// >>> tb/flash_protect_nonblocking_calls_bench.sv
// self-checking bench of the flash system-call sequencer
`timescale 1ns/1ps
`include "flash_seq_cfg.svh"
module flash_protect_nonblocking_calls_bench
    import flash_seq_pkg::*;
;
    localparam int PH = 40;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        spc_irq, flash_op_valid, ld, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, sram_param, sram_addr, rd, ld_data;
    logic [1:0]  flash_op, op_seen;
    logic [7:0]  flash_macro, chip_prot;
    logic [15:0] flash_row;
    logic [3:0]  ld_idx;
    int          miscompares, n_checks, cyc;

    flash_seq #(.PHASE_CYC(PH)) i_flash_seq (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sram_param(sram_param),
        .sram_addr(sram_addr), .spc_irq(spc_irq),
        .flash_op_valid(flash_op_valid), .flash_op(flash_op),
        .flash_macro(flash_macro), .flash_row(flash_row),
        .chip_prot(chip_prot));
    sram_param_model i_sram_param_model (
        .pclk(pclk), .ld(ld), .ld_idx(ld_idx), .ld_data(ld_data),
        .sram_addr(sram_addr), .sram_param(sram_param));

    //------------------------------------------------------------
    // clock, hang guard and verdict
    //------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // whole run is under a thousand cycles; this ceiling only cuts hangs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(string n, logic e, logic g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask

    //------------------------------------------------------------
    // bus cycles and call helpers
    //------------------------------------------------------------
    // apb master: hold the request until pready is seen high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic load(logic [3:0] i, logic [31:0] d);
        @(posedge pclk);
        ld      <= 1'b1;
        ld_idx  <= i;
        ld_data <= d;
        @(posedge pclk);
        ld      <= 1'b0;
    endtask
    task automatic call(logic [31:0] arg, logic [15:0] op);
        op_seen = 2'bxx;
        apb(1'b1, `ADDR_ARG, arg);
        apb(1'b1, `ADDR_REQ, {`REQ_FLAG, op});
    endtask
    // status may land a few cycles after the request: poll, bounded
    task automatic expect_arg(logic [31:0] e);
        for (int i = 0; i < 30; i++) begin
            apb(1'b0, `ADDR_ARG, 32'h0);
            if (rd === e) break;
        end
        chk_word("status word", e, rd);
    endtask
    task automatic wait_irq(phase_t e);
        for (int i = 0; i < 300; i++) begin
            @(posedge pclk);
            if (flash_op_valid === 1'b1) op_seen = flash_op;
            if (spc_irq === 1'b1) break;
        end
        chk_bit("phase end pulse", 1'b1, spc_irq);
        chk_word("phase", {30'h0, e}, {30'h0, op_seen});
    endtask

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic t_reset_map();
        chk_word("chip_prot pin", 32'h01, {24'h0, chip_prot});
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk_bit("unmapped write err", 1'b1, err);
        apb(1'b0, 12'h010, 32'h0);
        chk_word("unmapped read", 32'h0, rd);
    endtask
    task automatic prot(logic [7:0] m, logic [7:0] lv, logic [7:0] ex);
        call({m, lv, `KEY2_PROT, `KEY1}, `OP_PROT);
        wait_irq(PH_PROTECT);
        chk_word("macro", {24'h0, m}, {24'h0, flash_macro});
        expect_arg(`ST_OK);
        apb(1'b0, `ADDR_CHIPPROT, 32'h0);
        chk_word("chip level", {24'h0, ex}, rd);
    endtask
    task automatic t_protect();
        prot(8'h00, `LVL_PROT, `LVL_PROT);
        prot(8'h00, `LVL_KILL, `LVL_KILL);
        prot(8'h00, `LVL_OPEN, `LVL_OPEN);
        prot(8'h01, `LVL_KILL, `LVL_OPEN);
        call({8'h00, `LVL_PROT, 8'hE1, `KEY1}, `OP_PROT);
        expect_arg(`ST_BADKEY);
        call({8'h02, `LVL_PROT, `KEY2_PROT, `KEY1}, `OP_PROT);
        expect_arg(`ST_BADADDR);
        chk_word("level kept", 32'h01, {24'h0, chip_prot});
    endtask
    task automatic t_write_row();
        call(32'h20, `OP_WRITE);
        call({8'h00, `LVL_OPEN, `KEY2_PROT, `KEY1}, `OP_PROT);
        expect_arg(`ST_BUSY);
        apb(1'b0, `ADDR_STAT, 32'h0);
        chk_word("status reg", 32'h0000_000B, rd);
        wait_irq(PH_PREPROG);
        chk_word("row", 32'h5, {16'h0, flash_row});
        call({8'h00, `LVL_OPEN, `KEY2_PROT, `KEY1}, `OP_PROT);
        expect_arg(`ST_PENDING);
        call(32'h20, `OP_RESUME);
        expect_arg(`ST_BADKEY);
        call(32'h24, `OP_RESUME);
        wait_irq(PH_ERASE);
        expect_arg(`ST_OK);
        call(32'h24, `OP_RESUME);
        wait_irq(PH_PROGRAM);
        call(32'h24, `OP_RESUME);
        expect_arg(`ST_OK);
        chk_bit("idle after write", 1'b0, flash_op_valid);
        call(32'h24, `OP_RESUME);
        expect_arg(`ST_RESUME_DONE);
    endtask
    task automatic t_prog_row();
        call(32'h2C, `OP_WRITE);
        expect_arg(`ST_BADKEY);
        call(32'h28, `OP_PROG);
        wait_irq(PH_PROGRAM);
        chk_word("row", 32'h7, {16'h0, flash_row});
        call(32'h24, `OP_RESUME);
        expect_arg(`ST_OK);
        call(32'h24, `OP_RESUME);
        expect_arg(`ST_RESUME_DONE);
    endtask
    // clock enable low must hold a running phase where it stands
    task automatic t_freeze();
        call({8'h01, `LVL_OPEN, `KEY2_PROT, `KEY1}, `OP_PROT);
        ce <= 1'b0;
        repeat (3 * PH) @(posedge pclk);
        chk_bit("frozen phase", 1'b1, flash_op_valid);
        ce <= 1'b1;
        wait_irq(PH_PROTECT);
        expect_arg(`ST_OK);
    endtask

    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        ce      = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        ld      = 1'b0;
        ld_idx  = 4'h0;
        ld_data = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        load(4'h8, {16'h0005, `KEY2_WRITE, `KEY1});
        load(4'h9, {16'h0000, `KEY2_RESUME, `KEY1});
        load(4'hA, {16'h0007, `KEY2_PROG, `KEY1});
        load(4'hB, {16'h0005, `KEY2_PROG, `KEY1});
        t_reset_map();
        t_protect();
        t_write_row();
        t_prog_row();
        t_freeze();
        conclude();
    end
endmodule
